// >>> sco_clock_control.sv
/*
 * System clock select and oscillator control with four byte registers on AHB-Lite.
 * Assumes the halt and wake strobes and the pin-function level are synchronous to core_clk.
 */
`timescale 1ns/100ps

// What this block does
// R1 - Halt with both keeps: both oscillators run
// R2 - Halt high keep only: high oscillator runs
// R3 - Select field picks divider or low clock
// R4 - Bit 3 picks fast RC or crystal
// R5 - Bit 2 picks slow RC or crystal
// R6 - Bit 1 keeps high oscillator in halt
// R7 - Bit 0 keeps low oscillator in halt
// R8 - Bit 4 reads zero, ignores writes
// R9 - Two-bit code picks fast RC frequency
// R10 - New fast RC frequency applied once stable
// R11 - Fast RC enable or change clears stable
// R12 - Software matches fast RC to factory option
// R13 - Range bit picks crystal above 10MHz
// R14 - Range write ignored while crystal pins and high crystal enabled
// R15 - Software sets range before enabling crystal
// R16 - High crystal enable clears, then sets stable
// R17 - Bit 0 enables high crystal, resets 0
// R18 - Quick-start bit picks fast start or low power
// R19 - Quick-start frozen while low crystal clocks system
// R20 - Low crystal enable clears, then sets stable
// R21 - Bit 0 enables low crystal, resets 0
// R22 - Halt with no keeps: sleep, slow RC runs
// R23 - Halt low keep only: low oscillator runs
// R24 - Start-up counter per oscillator sets stable
// R25 - Clock mux switches only to stable source
module sco_clock_control
   import sco_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic haltReq,
   input wire logic wakeReq,
   input wire logic crystalPinsOn,
   output logic [2:0] sysclkSelect,
   output logic sysclkFromLow,
   output logic highSpeedSourceSelect,
   output logic lowSpeedSourceSelect,
   output logic [1:0] fastRcFreqOut,
   output logic fastRcRun,
   output logic highCrystalRun,
   output logic highCrystalRange,
   output logic lowCrystalRun,
   output logic lowCrystalQuickStart,
   output logic slowRcRun,
   output logic cpuClkOn,
   output logic sysClkOn,
   output logic highClkPeriphOn,
   output logic lowClkPeriphOn,
   output logic [2:0] haltMode
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [2:0] sel;
      logic hs;
      logic ls;
      logic keepHi;
      logic keepLo;
      logic [1:0] fastFreq;
      logic fastEn;
      logic hiRange;
      logic hiEn;
      logic loQuick;
      logic loEn;
      logic [NUM_OSC-1:0] stable;
      logic [NUM_OSC-1:0][CNT_W-1:0] cnt;
      logic [2:0] appSel;
      logic appHs;
      logic appLs;
      logic [1:0] fastFreqApp;
      sco_mode_t mode;
      logic dpValid;
      logic dpWrite;
      logic [1:0] dpIdx;
      logic [7:0] rdata;
   } sco_state_t;

   sco_state_t state_reg;
   sco_state_t state_next;

   // Low crystal is the running system clock
   function automatic logic lowXtalIsSys(input logic [2:0] sel, input logic ls);
      lowXtalIsSys = (sel == SEL_LOW_SPEED) && ls;
   endfunction : lowXtalIsSys

   logic addrHit;
   logic [1:0] addrIdx;
   logic [7:0] wb;
   logic wrSys;
   logic wrFast;
   logic wrHigh;
   logic wrLow;
   logic [NUM_OSC-1:0] oscEn;
   logic [NUM_OSC-1:0] restart;
   logic [NUM_OSC-1:0][CNT_W-1:0] startCyc;
   logic targetStable;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   always_comb begin
      addrHit = 1'b1;
      addrIdx = IDX_SYS;
      if (haddr == ADDR_SYSTEM_CLOCK_CONTROL) begin
         addrIdx = IDX_SYS;
      end else if (haddr == ADDR_INTERNAL_FAST_RC_CONTROL) begin
         addrIdx = IDX_FAST;
      end else if (haddr == ADDR_HIGH_CRYSTAL_CONTROL) begin
         addrIdx = IDX_HIGH;
      end else if (haddr == ADDR_LOW_CRYSTAL_CONTROL) begin
         addrIdx = IDX_LOW;
      end else begin
         addrHit = 1'b0;
      end
   end

   assign startCyc[OSC_FAST] = FAST_RC_START_CYC;
   assign startCyc[OSC_HIGH] = HI_XTAL_START_CYC;
   assign startCyc[OSC_LOW] = LO_XTAL_START_CYC;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      wb = hwdata[7:0];
      wrSys = state_reg.dpValid && state_reg.dpWrite && (state_reg.dpIdx == IDX_SYS);
      wrFast = state_reg.dpValid && state_reg.dpWrite && (state_reg.dpIdx == IDX_FAST);
      wrHigh = state_reg.dpValid && state_reg.dpWrite && (state_reg.dpIdx == IDX_HIGH);
      wrLow = state_reg.dpValid && state_reg.dpWrite && (state_reg.dpIdx == IDX_LOW);
      restart = '0;
      // R8 unimplemented bit
      // R3 R4 R5 R6 R7 system clock fields
      if (wrSys) begin
         state_next.sel = wb[SEL_HI:SEL_LO];
         state_next.hs = wb[HS_BIT];
         state_next.ls = wb[LS_BIT];
         state_next.keepHi = wb[KEEP_HI_BIT];
         state_next.keepLo = wb[KEEP_LO_BIT];
      end
      // R9 R11 fast RC fields and restart
      if (wrFast) begin
         state_next.fastFreq = wb[FREQ_HI:FREQ_LO];
         state_next.fastEn = wb[ENABLE_BIT];
         restart[OSC_FAST] = (wb[ENABLE_BIT] && !state_reg.fastEn)
            || (wb[FREQ_HI:FREQ_LO] != state_reg.fastFreq);
      end
      // R17 R16 high crystal enable
      if (wrHigh) begin
         state_next.hiEn = wb[ENABLE_BIT];
         restart[OSC_HIGH] = wb[ENABLE_BIT] && !state_reg.hiEn;
         // R14 range write lock
         if (!(crystalPinsOn && state_reg.hiEn)) begin
            state_next.hiRange = wb[MODE_BIT];
         end
      end
      // R21 R20 low crystal enable
      if (wrLow) begin
         state_next.loEn = wb[ENABLE_BIT];
         restart[OSC_LOW] = wb[ENABLE_BIT] && !state_reg.loEn;
         // R19 quick-start lock
         if (!lowXtalIsSys(state_reg.appSel, state_reg.appLs)) begin
            state_next.loQuick = wb[MODE_BIT];
         end
      end
      oscEn = {state_next.loEn, state_next.hiEn, state_next.fastEn};
      // R24 start-up counters
      for (int i = 0; i < NUM_OSC; i++) begin
         if (!oscEn[i]) begin
            state_next.stable[i] = 1'b0;
            state_next.cnt[i] = CNT_ZERO;
         end else if (restart[i]) begin
            state_next.stable[i] = 1'b0;
            state_next.cnt[i] = startCyc[i];
         end else if (state_reg.cnt[i] != CNT_ZERO) begin
            state_next.cnt[i] = state_reg.cnt[i] - CNT_ONE;
            if (state_reg.cnt[i] == CNT_ONE) begin
               state_next.stable[i] = 1'b1;
            end
         end
      end
      // R10 apply new fast RC frequency
      if (state_reg.stable[OSC_FAST]) begin
         state_next.fastFreqApp = state_reg.fastFreq;
      end
      // R25 switch only to a stable source
      if (state_reg.sel == SEL_LOW_SPEED) begin
         targetStable = state_reg.ls ? state_reg.stable[OSC_LOW] : 1'b1;
      end else begin
         targetStable = state_reg.hs ? state_reg.stable[OSC_HIGH] : state_reg.stable[OSC_FAST];
      end
      if (targetStable) begin
         state_next.appSel = state_reg.sel;
         state_next.appHs = state_reg.hs;
         state_next.appLs = state_reg.ls;
      end
      // R1 R2 R22 R23 halt mode entry
      if (state_reg.mode == MODE_RUN) begin
         if (haltReq) begin
            case ({state_reg.keepHi, state_reg.keepLo})
               2'b11: state_next.mode = HALT_BOTH_OSC_ON_MODE;
               2'b10: state_next.mode = HALT_HIGH_OSC_ONLY_MODE;
               2'b01: state_next.mode = HALT_LOW_OSC_ONLY_MODE;
               default: state_next.mode = MODE_SLEEP;
            endcase
         end
      end else if (wakeReq) begin
         state_next.mode = MODE_RUN;
      end
      // Bus address phase
      state_next.dpValid = 1'b0;
      state_next.dpWrite = 1'b0;
      if (hsel && hready && htrans[HTRANS_ACTIVE_BIT]) begin
         state_next.dpValid = addrHit;
         state_next.dpWrite = hwrite;
         state_next.dpIdx = addrIdx;
         state_next.rdata = BYTE_ZERO;
         if (addrHit && !hwrite) begin
            case (addrIdx)
               IDX_SYS: begin
                  state_next.rdata[SEL_HI:SEL_LO] = state_next.sel;
                  state_next.rdata[HS_BIT] = state_next.hs;
                  state_next.rdata[LS_BIT] = state_next.ls;
                  state_next.rdata[KEEP_HI_BIT] = state_next.keepHi;
                  state_next.rdata[KEEP_LO_BIT] = state_next.keepLo;
               end
               IDX_FAST: begin
                  state_next.rdata[FREQ_HI:FREQ_LO] = state_next.fastFreq;
                  state_next.rdata[STABLE_BIT] = state_next.stable[OSC_FAST];
                  state_next.rdata[ENABLE_BIT] = state_next.fastEn;
               end
               IDX_HIGH: begin
                  state_next.rdata[MODE_BIT] = state_next.hiRange;
                  state_next.rdata[STABLE_BIT] = state_next.stable[OSC_HIGH];
                  state_next.rdata[ENABLE_BIT] = state_next.hiEn;
               end
               default: begin
                  state_next.rdata[MODE_BIT] = state_next.loQuick;
                  state_next.rdata[STABLE_BIT] = state_next.stable[OSC_LOW];
                  state_next.rdata[ENABLE_BIT] = state_next.loEn;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg <= '0;
         state_reg.sel <= SEL_RST;
         state_reg.fastFreq <= FREQ_RST;
         state_reg.fastEn <= FAST_EN_RST;
         state_reg.hiEn <= BIT_RST;
         state_reg.loEn <= BIT_RST;
         state_reg.cnt[OSC_FAST] <= FAST_RC_START_CYC;
         state_reg.appSel <= SEL_RST;
         state_reg.fastFreqApp <= FREQ_RST;
         state_reg.mode <= MODE_RUN;
      end else if (clkEn) begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = {RDATA_PAD, state_reg.rdata};
   assign sysclkSelect = state_reg.appSel;
   assign sysclkFromLow = (state_reg.appSel == SEL_LOW_SPEED);
   assign highSpeedSourceSelect = state_reg.appHs;
   assign lowSpeedSourceSelect = state_reg.appLs;
   assign fastRcFreqOut = state_reg.fastFreqApp;
   // R13 R18 crystal mode bits
   assign highCrystalRange = state_reg.hiRange;
   assign lowCrystalQuickStart = state_reg.loQuick;
   assign haltMode = state_reg.mode;
   assign cpuClkOn = (state_reg.mode == MODE_RUN);
   assign highClkPeriphOn = (state_reg.mode == MODE_RUN)
      || (state_reg.mode == HALT_BOTH_OSC_ON_MODE)
      || (state_reg.mode == HALT_HIGH_OSC_ONLY_MODE);
   assign lowClkPeriphOn = (state_reg.mode == MODE_RUN)
      || (state_reg.mode == HALT_BOTH_OSC_ON_MODE)
      || (state_reg.mode == HALT_LOW_OSC_ONLY_MODE);
   assign sysClkOn = sysclkFromLow ? lowClkPeriphOn : highClkPeriphOn;
   assign fastRcRun = state_reg.fastEn && highClkPeriphOn;
   assign highCrystalRun = state_reg.hiEn && highClkPeriphOn;
   assign lowCrystalRun = state_reg.loEn && lowClkPeriphOn;
   // R22 slow RC always on for the watchdog
   assign slowRcRun = 1'b1;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_unused_bit_zero: assert property ( // R8
      @(posedge core_clk) disable iff (reset)
      $past(state_reg.dpValid) |-> !hrdata[UNUSED_SYS_BIT])
      else $error("Unimplemented bit read as one");

   a_halt_both_on: assert property ( // R1
      @(posedge core_clk) disable iff (reset)
      (clkEn && haltReq && cpuClkOn && state_reg.keepHi && state_reg.keepLo)
      |=> (highClkPeriphOn && lowClkPeriphOn && !cpuClkOn))
      else $error("Halt with both keeps lost a clock");

   a_halt_high_only: assert property ( // R2
      @(posedge core_clk) disable iff (reset)
      (clkEn && haltReq && cpuClkOn && state_reg.keepHi && !state_reg.keepLo)
      |=> (highClkPeriphOn && !lowClkPeriphOn && !cpuClkOn))
      else $error("Halt with high keep wrong clocks");

   a_halt_low_only: assert property ( // R23
      @(posedge core_clk) disable iff (reset)
      (clkEn && haltReq && cpuClkOn && !state_reg.keepHi && state_reg.keepLo)
      |=> (!highClkPeriphOn && lowClkPeriphOn && !cpuClkOn))
      else $error("Halt with low keep wrong clocks");

   a_sleep_clocks: assert property ( // R22
      @(posedge core_clk) disable iff (reset)
      (state_reg.mode == MODE_SLEEP) |-> (!lowClkPeriphOn && !highClkPeriphOn && slowRcRun))
      else $error("Sleep clocks wrong");

   a_fast_restart: assert property ( // R11
      @(posedge core_clk) disable iff (reset)
      (clkEn && wrFast && state_next.fastEn && (wb[FREQ_HI:FREQ_LO] != state_reg.fastFreq))
      |=> !state_reg.stable[OSC_FAST] ##1 (state_reg.cnt[OSC_FAST] != CNT_ZERO || !clkEn))
      else $error("Fast RC stable not cleared on change");

   a_stable_count: assert property ( // R24
      @(posedge core_clk) disable iff (reset)
      $rose(state_reg.stable[OSC_HIGH]) |-> ($past(state_reg.cnt[OSC_HIGH]) == CNT_ONE))
      else $error("High crystal stable set early");

   a_range_locked: assert property ( // R14
      @(posedge core_clk) disable iff (reset)
      (clkEn && wrHigh && crystalPinsOn && state_reg.hiEn) |=> $stable(highCrystalRange))
      else $error("Range bit changed while locked");

   a_quick_locked: assert property ( // R19
      @(posedge core_clk) disable iff (reset)
      lowXtalIsSys(state_reg.appSel, state_reg.appLs) && $past(lowXtalIsSys(state_reg.appSel,
         state_reg.appLs)) |-> $stable(lowCrystalQuickStart))
      else $error("Quick start changed while low crystal clocks system");

   a_mux_stable: assert property ( // R25
      @(posedge core_clk) disable iff (reset)
      $changed(sysclkSelect) && !sysclkFromLow && !highSpeedSourceSelect
      |-> $past(state_reg.stable[OSC_FAST]))
      else $error("Switched to unstable fast RC");

   a_freq_apply: assert property ( // R10
      @(posedge core_clk) disable iff (reset)
      $changed(fastRcFreqOut) |-> $past(state_reg.stable[OSC_FAST]))
      else $error("Fast RC frequency applied before stable");

endmodule : sco_clock_control

// >>> sco_clock_control_tb_top.sv
/*
 * Self-checking testbench for the system clock and oscillator control block.
 * Assumes the block is the only AHB-Lite slave, so its hreadyout drives hready.
 */
`timescale 1ns/100ps

`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module sco_clock_control_tb_top
   import sco_pkg::*;
;
   // ****************************************************************
   // Signals and tasks
   // ****************************************************************
   logic core_clk, reset, clkEn, hsel, hwrite, haltReq, wakeReq, crystalPinsOn;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, fastRcFreqOut, prevF;
   logic [2:0] hsize, sysclkSelect, haltMode, c;
   logic hreadyout, hresp, sysclkFromLow, highSpeedSourceSelect, lowSpeedSourceSelect;
   logic fastRcRun, highCrystalRun, highCrystalRange, lowCrystalRun, lowCrystalQuickStart;
   logic slowRcRun, cpuClkOn, sysClkOn, highClkPeriphOn, lowClkPeriphOn;
   wire logic hready;
   logic [31:0] seed;
   logic [7:0] q, last;
   logic [1:0] k;
   int n_errors, comparisons;

   assign hready = hreadyout;

   sco_clock_control dut (.core_clk(core_clk), .reset(reset), .clkEn(clkEn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .haltReq(haltReq), .wakeReq(wakeReq), .crystalPinsOn(crystalPinsOn),
      .sysclkSelect(sysclkSelect), .sysclkFromLow(sysclkFromLow),
      .highSpeedSourceSelect(highSpeedSourceSelect), .lowSpeedSourceSelect(lowSpeedSourceSelect),
      .fastRcFreqOut(fastRcFreqOut), .fastRcRun(fastRcRun), .highCrystalRun(highCrystalRun),
      .highCrystalRange(highCrystalRange), .lowCrystalRun(lowCrystalRun),
      .lowCrystalQuickStart(lowCrystalQuickStart), .slowRcRun(slowRcRun), .cpuClkOn(cpuClkOn),
      .sysClkOn(sysClkOn), .highClkPeriphOn(highClkPeriphOn), .lowClkPeriphOn(lowClkPeriphOn),
      .haltMode(haltMode));

   always begin
      #5;
      core_clk = ~core_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [7:0] sysExp(input logic [7:0] d);
      sysExp = d & 8'hEF;
   endfunction : sysExp

   function automatic logic [2:0] modeExp(input logic [1:0] kk);
      case (kk)
         2'h0: modeExp = MODE_SLEEP;
         2'h1: modeExp = HALT_LOW_OSC_ONLY_MODE;
         2'h2: modeExp = HALT_HIGH_OSC_ONLY_MODE;
         default: modeExp = HALT_BOTH_OSC_ON_MODE;
      endcase
   endfunction : modeExp

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   // One single word transfer, entered just after a rising edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
      int i;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (hready !== 1'b1 && i < 20);
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      do begin
         @(posedge core_clk);
         i++;
      end while (hready !== 1'b1 && i < 40);
      q = hrdata[7:0];
      `CHECK("hresp", 1'b0, hresp)
      if (i >= 20) begin
         n_errors++;
         end_of_test();
      end
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rdchk(input string nm, input logic [31:0] a, input logic [7:0] ex);
      bus(1'b0, a, 8'h00);
      `CHECK(nm, ex, q)
   endtask : rdchk

   task automatic waitc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : waitc

   task automatic pulse(input logic h);
      if (h) begin
         haltReq <= 1'b1;
      end else begin
         wakeReq <= 1'b1;
      end
      @(posedge core_clk);
      haltReq <= 1'b0;
      wakeReq <= 1'b0;
      #1;
   endtask : pulse

   // ****************************************************************
   // Stimulus
   // ****************************************************************
   initial begin
      core_clk = 1'b0;
      reset = 1'b1;
      clkEn = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      haltReq = 1'b0;
      wakeReq = 1'b0;
      crystalPinsOn = 1'b0;
      n_errors = 0;
      comparisons = 0;
      seed = 32'h2F67_5090;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      `CHECK("cpuOn", 1'b1, cpuClkOn)
      `CHECK("rcRun", 1'b1, fastRcRun)
      @(posedge core_clk);
      rdchk("sys", ADDR_SYSTEM_CLOCK_CONTROL, 8'h00);
      rdchk("fast", ADDR_INTERNAL_FAST_RC_CONTROL, 8'h01);
      rdchk("high", ADDR_HIGH_CRYSTAL_CONTROL, 8'h00);
      rdchk("low", ADDR_LOW_CRYSTAL_CONTROL, 8'h00);
      repeat (6) begin
         seed = lfsr(seed);
         last = seed[7:0];
         wr(ADDR_SYSTEM_CLOCK_CONTROL, last);
         rdchk("sys", ADDR_SYSTEM_CLOCK_CONTROL, sysExp(last));
      end
      wr(32'h0000_0010, 8'hFF);
      rdchk("unmapped", 32'h0000_0010, 8'h00);
      rdchk("sys", ADDR_SYSTEM_CLOCK_CONTROL, sysExp(last));
      repeat (int'(FAST_RC_START_CYC)) @(posedge core_clk);
      rdchk("fastOk", ADDR_INTERNAL_FAST_RC_CONTROL, 8'h03);
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         wr(ADDR_SYSTEM_CLOCK_CONTROL, {c, 5'h00});
         waitc(3);
         `CHECK("select", c, sysclkSelect)
         `CHECK("fromLow", (c == 3'h7), sysclkFromLow)
         `CHECK("lowSrc", 1'b0, lowSpeedSourceSelect)
         @(posedge core_clk);
      end
      $display("test select done");
      wr(ADDR_SYSTEM_CLOCK_CONTROL, 8'h08);
      waitc(3);
      `CHECK("hiSrcWait", 1'b0, highSpeedSourceSelect)
      @(posedge core_clk);
      crystalPinsOn <= 1'b1;
      wr(ADDR_HIGH_CRYSTAL_CONTROL, 8'h01);
      rdchk("hiStart", ADDR_HIGH_CRYSTAL_CONTROL, 8'h01);
      `CHECK("hiRun", 1'b1, highCrystalRun)
      waitc(int'(HI_XTAL_START_CYC) + 10);
      `CHECK("hiSrc", 1'b1, highSpeedSourceSelect)
      @(posedge core_clk);
      rdchk("hiStable", ADDR_HIGH_CRYSTAL_CONTROL, 8'h03);
      wr(ADDR_HIGH_CRYSTAL_CONTROL, 8'h05);
      rdchk("rangeLock", ADDR_HIGH_CRYSTAL_CONTROL, 8'h03);
      crystalPinsOn <= 1'b0;
      wr(ADDR_HIGH_CRYSTAL_CONTROL, 8'h05);
      rdchk("rangeSet", ADDR_HIGH_CRYSTAL_CONTROL, 8'h07);
      `CHECK("range", 1'b1, highCrystalRange)
      $display("test high crystal done");
      prevF = 2'h0;
      for (int i = 1; i < 5; i++) begin
         k = i[1:0];
         wr(ADDR_INTERNAL_FAST_RC_CONTROL, {4'h0, k, 2'b01});
         rdchk("rcChange", ADDR_INTERNAL_FAST_RC_CONTROL, {4'h0, k, 2'b01});
         `CHECK("freqOld", prevF, fastRcFreqOut)
         waitc(int'(FAST_RC_START_CYC) + 10);
         `CHECK("freqNew", k, fastRcFreqOut)
         @(posedge core_clk);
         rdchk("rcStable", ADDR_INTERNAL_FAST_RC_CONTROL, {4'h0, k, 2'b11});
         prevF = k;
      end
      $display("test fast rc done");
      wr(ADDR_LOW_CRYSTAL_CONTROL, 8'h05);
      rdchk("loStart", ADDR_LOW_CRYSTAL_CONTROL, 8'h05);
      waitc(int'(LO_XTAL_START_CYC) + 10);
      @(posedge core_clk);
      rdchk("loStable", ADDR_LOW_CRYSTAL_CONTROL, 8'h07);
      wr(ADDR_SYSTEM_CLOCK_CONTROL, 8'hEC);
      waitc(3);
      `CHECK("fromLow", 1'b1, sysclkFromLow)
      `CHECK("loSrc", 1'b1, lowSpeedSourceSelect)
      @(posedge core_clk);
      wr(ADDR_LOW_CRYSTAL_CONTROL, 8'h01);
      rdchk("qsLock", ADDR_LOW_CRYSTAL_CONTROL, 8'h07);
      `CHECK("qs", 1'b1, lowCrystalQuickStart)
      wr(ADDR_SYSTEM_CLOCK_CONTROL, 8'h0C);
      waitc(3);
      @(posedge core_clk);
      wr(ADDR_LOW_CRYSTAL_CONTROL, 8'h01);
      rdchk("qsFree", ADDR_LOW_CRYSTAL_CONTROL, 8'h03);
      `CHECK("qsOff", 1'b0, lowCrystalQuickStart)
      $display("test low crystal done");
      clkEn <= 1'b0;
      pulse(1'b1);
      `CHECK("frozen", MODE_RUN, haltMode)
      @(posedge core_clk);
      clkEn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         wr(ADDR_SYSTEM_CLOCK_CONTROL, 8'h0C | {6'h00, k});
         pulse(1'b1);
         `CHECK("mode", modeExp(k), haltMode)
         `CHECK("cpuOff", 1'b0, cpuClkOn)
         `CHECK("hiKeep", k[1], highCrystalRun)
         `CHECK("loKeep", k[0], lowCrystalRun)
         `CHECK("rcKeep", k[1], fastRcRun)
         `CHECK("hiPer", k[1], highClkPeriphOn)
         `CHECK("loPer", k[0], lowClkPeriphOn)
         `CHECK("sysOn", k[1], sysClkOn)
         `CHECK("slowRc", 1'b1, slowRcRun)
         @(posedge core_clk);
         pulse(1'b0);
         `CHECK("wake", MODE_RUN, haltMode)
         `CHECK("cpuOn", 1'b1, cpuClkOn)
         @(posedge core_clk);
      end
      $display("test halt done");
      end_of_test();
   end

endmodule : sco_clock_control_tb_top

// >>> sco_pkg.sv
/*
 * Constants, register map and types for the system clock and oscillator control block.
 * Assumes a single 100 MHz core clock and a word-wide AHB-Lite register port.
 */
package sco_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned CNT_W = 12;
   localparam int unsigned FAST_RC_START_NS = 2000;
   localparam int unsigned HI_XTAL_START_NS = 10000;
   localparam int unsigned LO_XTAL_START_NS = 20000;
   localparam logic [CNT_W-1:0] FAST_RC_START_CYC =
      CNT_W'((FAST_RC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] HI_XTAL_START_CYC =
      CNT_W'((HI_XTAL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] LO_XTAL_START_CYC =
      CNT_W'((LO_XTAL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [31:0] ADDR_SYSTEM_CLOCK_CONTROL = 32'h0000_0000;
   localparam logic [31:0] ADDR_INTERNAL_FAST_RC_CONTROL = 32'h0000_0004;
   localparam logic [31:0] ADDR_HIGH_CRYSTAL_CONTROL = 32'h0000_0008;
   localparam logic [31:0] ADDR_LOW_CRYSTAL_CONTROL = 32'h0000_000C;
   localparam logic [1:0] IDX_SYS = 2'h0;
   localparam logic [1:0] IDX_FAST = 2'h1;
   localparam logic [1:0] IDX_HIGH = 2'h2;
   localparam logic [1:0] IDX_LOW = 2'h3;
   localparam int unsigned HTRANS_ACTIVE_BIT = 1;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned SEL_HI = 7;
   localparam int unsigned SEL_LO = 5;
   localparam int unsigned UNUSED_SYS_BIT = 4;
   localparam int unsigned HS_BIT = 3;
   localparam int unsigned LS_BIT = 2;
   localparam int unsigned KEEP_HI_BIT = 1;
   localparam int unsigned KEEP_LO_BIT = 0;
   localparam int unsigned FREQ_HI = 3;
   localparam int unsigned FREQ_LO = 2;
   localparam int unsigned MODE_BIT = 2;
   localparam int unsigned STABLE_BIT = 1;
   localparam int unsigned ENABLE_BIT = 0;

   // ****************************************************************
   // Codes and reset values
   // ****************************************************************
   localparam logic [2:0] SEL_LOW_SPEED = 3'h7;
   localparam logic [2:0] SEL_RST = 3'h0;
   localparam logic [1:0] FREQ_RST = 2'h0;
   localparam logic FAST_EN_RST = 1'b1;
   localparam logic BIT_RST = 1'b0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [23:0] RDATA_PAD = 24'h00_0000;
   localparam int unsigned OSC_FAST = 0;
   localparam int unsigned OSC_HIGH = 1;
   localparam int unsigned OSC_LOW = 2;
   localparam int unsigned NUM_OSC = 3;

   typedef enum logic [2:0] {
      MODE_RUN = 3'b000,
      MODE_SLEEP = 3'b001,
      HALT_LOW_OSC_ONLY_MODE = 3'b010,
      HALT_BOTH_OSC_ON_MODE = 3'b011,
      HALT_HIGH_OSC_ONLY_MODE = 3'b100
   } sco_mode_t;

endpackage : sco_pkg
